/* verilog/output_scaling_linearization.v */
// What this block does
// [R1] linearizer input limited to 0..32767
// [R2] input gain and offset scale ahead
// [R3] output gain/offset map analog output
// [R4] output gain/offset map pwm duty
// [R5] output limited between low/high clamps
// [R6] setup bits 14:12 barrel range; 15,6 reserved
// [R7] bits 11:10 pwm rate, reserved on analog
// [R8] bits 9:8 short detection response mode
// [R9] bit7 error band when locked, else high
// [R10] bit7 pwm polarity, effective once locked
// [R11] bit5 supply supervision threshold set
// [R12] bit4 enables output pin communication
// [R13] bit3 high disables overvoltage detection
// [R14] bit2 latches diagnosis till power-on
// [R15] bit1 low: errors force error band
// [R16] bit1 low: errors force pwm error mode
// [R17] bit0 set locks configuration memory
// [R18] short detection needs lock plus power-on
// [R19] sixteen equal segments, linear interpolation
// [R20] programmer supplies monotonic characteristic
// [R21] zero setpoints give neutral straight line
// [R22] pwm rate field frequency mapping
// [R23] barrel shifter picks 16 of 22 bits
// [R24] clamp scaled input before segment select
// [R25] top four bits segment, rest fraction
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "output_scaling_map.vh"
module output_scaling_linearization #(
    parameter PWM_VARIANT = 0
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        porEvent,
    input  wire [21:0] decimWord,
    input  wire        diagError,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [15:0] outValue_r,
    output reg  [1:0]  pwmRateSel_r,
    output reg  [3:0]  pwmPeriodLog_r,
    output reg         pwmPolarity_r,
    output reg         errorBandLow_r,
    output reg         forceError_r,
    output reg  [1:0]  shortMode_r,
    output reg         supplyNormal_r,
    output reg         outputPinCommEnable_r,
    output reg         overvoltageEnable_r,
    output reg         diagLatched_r,
    output reg         memoryLocked_r
);

////////////////////////////////////////////////////////////////////////////
// registers

reg  [15:0] linGain_r;
reg  [15:0] linOffset_r;
reg  [15:0] outGain_r;
reg  [15:0] outOffset_r;
reg  [15:0] clampHigh_r;
reg  [15:0] clampLow_r;
reg  [15:0] setupWord_r;
reg  [15:0] setpointTable_r [0:15];
reg  [15:0] sample_r;
reg  [15:0] linOut_r;
reg         lockAtPor_r;
reg         awPend_r;
reg         wPend_r;
reg  [11:0] awAddr_r;
reg  [31:0] wData_r;
reg  [3:0]  wStrb_r;

// merge byte lanes of a 16-bit register
function [15:0] mergeLanes;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
        mergeLanes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
        mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
endfunction

// saturate a signed 18-bit value into a 16-bit window
function [15:0] sat16;
    input signed [17:0] v;
    input        [15:0] lo;
    input        [15:0] hi;
    begin
        if (v < $signed({{2{lo[15]}}, lo})) begin
            sat16 = lo;
        end else if (v > $signed({{2{hi[15]}}, hi})) begin
            sat16 = hi;
        end else begin
            sat16 = v[15:0];
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// axi write channel

wire        doWrite = awPend_r && wPend_r && !s_axi_bvalid;
wire        setpointHit = (awAddr_r >= `OFS_SETPOINT_TABLE_BASE) &&
                          (awAddr_r <= `OFS_SETPOINT_TABLE_LAST);
wire [3:0]  wIndex = awAddr_r[5:2];
wire        locked = setupWord_r[`SU_LOCK];
integer     i;

always @(posedge clock) begin
    if (sys_rst) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= 2'b00;
        awPend_r      <= 1'b0;
        wPend_r       <= 1'b0;
        awAddr_r      <= 12'h000;
        wData_r       <= 32'h00000000;
        wStrb_r       <= 4'h0;
        linGain_r     <= `RST_LIN_GAIN;
        linOffset_r   <= `RST_LIN_OFFSET;
        outGain_r     <= `RST_OUT_GAIN;
        outOffset_r   <= `RST_OUT_OFFSET;
        clampHigh_r   <= `RST_CLAMP_HIGH;
        clampLow_r    <= `RST_CLAMP_LOW;
        setupWord_r   <= `RST_SETUP;
        sample_r      <= 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            setpointTable_r[i] <= 16'h0000;
        end
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r      <= {s_axi_awaddr[11:2], 2'b00};
            awPend_r      <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wData_r      <= s_axi_wdata;
            wStrb_r      <= s_axi_wstrb;
            wPend_r      <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (doWrite) begin
            awPend_r     <= 1'b0;
            wPend_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            // configuration frozen once locked [R17]
            if (locked && awAddr_r != `OFS_SAMPLE_IN) begin
                s_axi_bresp <= 2'b10;
            end else if (awAddr_r == `OFS_LIN_GAIN) begin
                linGain_r <= mergeLanes(linGain_r, wData_r, wStrb_r); // [R2]
            end else if (awAddr_r == `OFS_LIN_OFFSET) begin
                linOffset_r <= mergeLanes(linOffset_r, wData_r, wStrb_r);
            end else if (awAddr_r == `OFS_OUT_GAIN) begin
                outGain_r <= mergeLanes(outGain_r, wData_r, wStrb_r);
            end else if (awAddr_r == `OFS_OUT_OFFSET) begin
                outOffset_r <= mergeLanes(outOffset_r, wData_r, wStrb_r);
            end else if (awAddr_r == `OFS_CLAMP_HIGH) begin
                clampHigh_r <= mergeLanes(clampHigh_r, wData_r, wStrb_r);
            end else if (awAddr_r == `OFS_CLAMP_LOW) begin
                clampLow_r <= mergeLanes(clampLow_r, wData_r, wStrb_r);
            end else if (awAddr_r == `OFS_SETUP) begin
                // reserved bits 15 and 6 stay zero [R6]
                setupWord_r <= mergeLanes(setupWord_r, wData_r, wStrb_r) &
                               `SU_WMASK;
            end else if (awAddr_r == `OFS_SAMPLE_IN) begin
                sample_r <= mergeLanes(sample_r, wData_r, wStrb_r);
            end else if (setpointHit) begin
                setpointTable_r[wIndex] <=
                    mergeLanes(setpointTable_r[wIndex], wData_r, wStrb_r);
            end else begin
                s_axi_bresp <= 2'b10;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// axi read channel

wire [15:0] statusWord = {13'h0000, lockAtPor_r, memoryLocked_r,
                          forceError_r};

always @(posedge clock) begin
    if (sys_rst) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        s_axi_rdata   <= 32'h00000000;
        if (s_axi_araddr[11:2] == `OFS_LIN_GAIN >> 2) begin
            s_axi_rdata[15:0] <= linGain_r;
        end else if (s_axi_araddr[11:2] == `OFS_LIN_OFFSET >> 2) begin
            s_axi_rdata[15:0] <= linOffset_r;
        end else if (s_axi_araddr[11:2] == `OFS_OUT_GAIN >> 2) begin
            s_axi_rdata[15:0] <= outGain_r;
        end else if (s_axi_araddr[11:2] == `OFS_OUT_OFFSET >> 2) begin
            s_axi_rdata[15:0] <= outOffset_r;
        end else if (s_axi_araddr[11:2] == `OFS_CLAMP_HIGH >> 2) begin
            s_axi_rdata[15:0] <= clampHigh_r;
        end else if (s_axi_araddr[11:2] == `OFS_CLAMP_LOW >> 2) begin
            s_axi_rdata[15:0] <= clampLow_r;
        end else if (s_axi_araddr[11:2] == `OFS_SETUP >> 2) begin
            s_axi_rdata[15:0] <= setupWord_r;
        end else if (s_axi_araddr[11:2] == `OFS_STATUS >> 2) begin
            s_axi_rdata[15:0] <= statusWord;
        end else if (s_axi_araddr[11:2] == `OFS_SAMPLE_IN >> 2) begin
            s_axi_rdata[15:0] <= sample_r;
        end else if (s_axi_araddr[11:2] == `OFS_RESULT >> 2) begin
            s_axi_rdata[15:0] <= outValue_r;
        end else if (s_axi_araddr[11:6] == 6'h01) begin
            s_axi_rdata[15:0] <= setpointTable_r[s_axi_araddr[5:2]];
        end else begin
            s_axi_rresp <= 2'b10;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// signal path

wire [2:0]  rangeSel = setupWord_r[`SU_RANGE_HI:`SU_RANGE_LO];
wire [21:0] shifted  = decimWord << (rangeSel - 3'd1);
// setting 1 widest, each step halves the range [R23]
wire [15:0] barrelOut = (rangeSel == 3'd0) ? sample_r : shifted[21:6];
wire signed [31:0] scaledProd = $signed(barrelOut) * $signed(linGain_r);
wire signed [17:0] scaledSum  = $signed(scaledProd[31:14]) +
                                $signed({{2{linOffset_r[15]}}, linOffset_r});
// scale then keep within 0..32767 [R2] [R24] [R1]
wire [15:0] linIn    = sat16(scaledSum, 16'h0000, `LIN_MAX);
wire [3:0]  segIdx   = linIn[14:11]; // [R25]
wire [10:0] segFrac  = linIn[10:0];
wire [15:0] spLo     = setpointTable_r[segIdx];
wire [15:0] spHi     = (segIdx == 4'hf) ? 16'h0000 :
                       setpointTable_r[segIdx + 4'h1];
// interpolated correction over straight line [R19] [R21]
wire signed [16:0] spDiff = $signed({spHi[15], spHi}) -
                            $signed({spLo[15], spLo});
wire signed [28:0] interp = spDiff * $signed({1'b0, segFrac});
wire signed [17:0] corr   = $signed({{2{spLo[15]}}, spLo}) +
                            $signed(interp[28:11]);
wire signed [17:0] linSum = $signed({2'b00, linIn}) + corr;
wire [15:0] linNext  = sat16(linSum, 16'h0000, `LIN_MAX);
wire signed [31:0] outProd = $signed(linOut_r) * $signed(outGain_r);
wire signed [17:0] outSum  = $signed(outProd[31:14]) +
                             $signed({{2{outOffset_r[15]}}, outOffset_r});

always @(posedge clock) begin
    if (sys_rst) begin
        linOut_r   <= 16'h0000;
        outValue_r <= 16'h0000;
    end else begin
        linOut_r   <= linNext;
        // output gain/offset then clamp window [R3] [R4] [R5]
        outValue_r <= sat16(outSum, clampLow_r, clampHigh_r);
    end
end

////////////////////////////////////////////////////////////////////////////
// setup word decode

always @(posedge clock) begin
    if (sys_rst) begin
        lockAtPor_r           <= 1'b0;
        memoryLocked_r        <= 1'b0;
        pwmRateSel_r          <= 2'b00;
        pwmPeriodLog_r        <= 4'hc;
        pwmPolarity_r         <= 1'b0;
        errorBandLow_r        <= 1'b0;
        forceError_r          <= 1'b0;
        shortMode_r           <= 2'b00;
        supplyNormal_r        <= 1'b0;
        outputPinCommEnable_r <= 1'b0;
        overvoltageEnable_r   <= 1'b1;
        diagLatched_r         <= 1'b0;
    end else begin
        memoryLocked_r <= locked; // [R17]
        if (porEvent) begin
            lockAtPor_r <= locked;
        end
        // active only after lock and a later power-on [R18]
        shortMode_r <= lockAtPor_r ?
                       setupWord_r[`SU_SHORT_HI:`SU_SHORT_LO] : 2'b00; // [R8]
        // reserved field on analog variant [R7]
        pwmRateSel_r <= PWM_VARIANT ?
                        setupWord_r[`SU_PWM_HI:`SU_PWM_LO] : 2'b00;
        // 11:2k/11b, 00:1k, 01:500, 10:250 all 12b [R22]
        pwmPeriodLog_r <= (PWM_VARIANT &&
                           setupWord_r[`SU_PWM_HI:`SU_PWM_LO] == 2'b11) ?
                          4'hb : 4'hc;
        pwmPolarity_r <= PWM_VARIANT && locked &&
                         setupWord_r[`SU_POL_BAND]; // [R10]
        errorBandLow_r <= !PWM_VARIANT && locked &&
                          setupWord_r[`SU_POL_BAND]; // [R9]
        supplyNormal_r        <= setupWord_r[`SU_SUPPLY]; // [R11]
        outputPinCommEnable_r <= setupWord_r[`SU_COMM]; // [R12]
        overvoltageEnable_r   <= !setupWord_r[`SU_OV_DIS]; // [R13]
        // latch till power-on or follow live condition [R14]
        if (porEvent) begin
            diagLatched_r <= diagError;
        end else if (setupWord_r[`SU_DIAG_LATCH]) begin
            diagLatched_r <= diagLatched_r | diagError;
        end else begin
            diagLatched_r <= diagError;
        end
        forceError_r <= !setupWord_r[`SU_DIAG_DIS] &&
                        (diagError || diagLatched_r); // [R15] [R16]
    end
end

endmodule

/* verilog/output_scaling_map.vh */
`ifndef OUTPUT_SCALING_MAP_VH
`define OUTPUT_SCALING_MAP_VH
// register byte addresses
`define OFS_LIN_GAIN      12'h000
`define OFS_LIN_OFFSET    12'h004
`define OFS_OUT_GAIN      12'h008
`define OFS_OUT_OFFSET    12'h00c
`define OFS_CLAMP_HIGH    12'h010
`define OFS_CLAMP_LOW     12'h014
`define OFS_SETUP         12'h018
`define OFS_STATUS        12'h01c
`define OFS_SAMPLE_IN     12'h020
`define OFS_RESULT        12'h024
`define OFS_SETPOINT_TABLE_BASE    12'h040
`define OFS_SETPOINT_TABLE_LAST    12'h07c
// reset values
`define RST_LIN_GAIN      16'h4000
`define RST_LIN_OFFSET    16'h0000
`define RST_OUT_GAIN      16'h4000
`define RST_OUT_OFFSET    16'h0000
`define RST_CLAMP_HIGH    16'h7fff
`define RST_CLAMP_LOW     16'h0000
`define RST_SETUP         16'h1000
// setup word fields
`define SU_RANGE_HI       14
`define SU_RANGE_LO       12
`define SU_PWM_HI         11
`define SU_PWM_LO         10
`define SU_SHORT_HI       9
`define SU_SHORT_LO       8
`define SU_POL_BAND       7
`define SU_SUPPLY         5
`define SU_COMM           4
`define SU_OV_DIS         3
`define SU_DIAG_LATCH     2
`define SU_DIAG_DIS       1
`define SU_LOCK           0
`define SU_WMASK          16'h7fbf
// linear input limit
`define LIN_MAX           16'h7fff
`endif

/* verification/output_scaling_checker.sv */
`timescale 1ns/100ps
`include "output_scaling_map.vh"
module output_scaling_checker #(
    parameter PWM_VARIANT = 0
) (
    input wire        clock,
    input wire        sys_rst,
    input wire        porEvent,
    input wire [11:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [1:0]  pwmRateSel_r,
    input wire [3:0]  pwmPeriodLog_r,
    input wire        pwmPolarity_r,
    input wire        errorBandLow_r,
    input wire [1:0]  shortMode_r,
    input wire        memoryLocked_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    read_answer_a:
        assert property (rdTaken |=> s_axi_rvalid)
        else $error("read answer missing");
    resp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    locked_refuse_a:
        assert property (wrTaken ##0 (memoryLocked_r &&
            s_axi_awaddr != `OFS_SAMPLE_IN) |->
            ##2 s_axi_bvalid && s_axi_bresp == 2'h2)
        else $error("locked write accepted");
    lock_sticky_a:
        assert property (memoryLocked_r |=> memoryLocked_r)
        else $error("lock released");
    short_locked_a:
        assert property (shortMode_r != 2'h0 |-> memoryLocked_r)
        else $error("short detection while unlocked");
    short_por_a:
        assert property ($changed(shortMode_r) |->
            $past(porEvent) || $past(porEvent, 2))
        else $error("short mode changed without power-on");
    band_locked_a:
        assert property (errorBandLow_r |->
            memoryLocked_r && PWM_VARIANT == 0)
        else $error("low band while unlocked");
    polarity_lock_a:
        assert property (pwmPolarity_r |->
            memoryLocked_r && PWM_VARIANT != 0)
        else $error("polarity active while unlocked");
    rate_res_a:
        assert property (pwmPeriodLog_r ==
            (pwmRateSel_r == 2'h3 ? 4'hb : 4'hc))
        else $error("pwm resolution mismatch");
    rate_reserved_a:
        assert property (PWM_VARIANT == 0 |-> pwmRateSel_r == 2'h0)
        else $error("pwm rate set on analog");
endmodule
bind output_scaling_linearization output_scaling_checker #(
    .PWM_VARIANT(PWM_VARIANT)
) chk_i (
    .clock(clock), .sys_rst(sys_rst), .porEvent(porEvent),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .pwmRateSel_r(pwmRateSel_r),
    .pwmPeriodLog_r(pwmPeriodLog_r), .pwmPolarity_r(pwmPolarity_r),
    .errorBandLow_r(errorBandLow_r), .shortMode_r(shortMode_r),
    .memoryLocked_r(memoryLocked_r)
);

/* verification/signal_source.sv */
`timescale 1ns/100ps
module signal_source (
    input  wire        clock,
    output reg         porEvent,
    output reg         diagError,
    output reg  [21:0] decimWord
);
    initial begin
        porEvent = 1'h0;
        diagError = 1'h0;
        decimWord = 22'h0;
    end
    // one sample level, window of barrel setting 1
    task set_level(input [15:0] v);
        decimWord <= {v, 6'h00};
    endtask
    task por_pulse;
        begin
            porEvent <= 1'h1;
            @(posedge clock);
            porEvent <= 1'h0;
        end
    endtask
endmodule

/* verification/output_scaling_linearization_tb.sv */
`timescale 1ns/100ps
`include "output_scaling_map.vh"
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
    err_count = err_count + 1; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module output_scaling_linearization_tb;
    reg         clock, sys_rst, awvalid, wvalid, bready, arvalid, rready;
    reg  [11:0] awaddr, araddr;
    reg  [31:0] wdata, rd;
    reg  [1:0]  resp;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp, rateSel, shortMode;
    wire [31:0] rdata;
    wire        por, diag, pol, bandLow, forceErr, supNorm, comm, ovEn;
    wire        diagLat, locked;
    wire [21:0] decim;
    wire [15:0] outValue;
    wire [3:0]  periodLog;
    integer     err_count, compares, cycles, i;
    reg  [31:0] tbl [0:3];
    signal_source signal_source_i (.clock(clock), .porEvent(por),
        .diagError(diag), .decimWord(decim));
    output_scaling_linearization output_scaling_linearization_i (
        .clock(clock), .sys_rst(sys_rst), .porEvent(por),
        .decimWord(decim), .diagError(diag), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .outValue_r(outValue),
        .pwmRateSel_r(rateSel), .pwmPeriodLog_r(periodLog),
        .pwmPolarity_r(pol), .errorBandLow_r(bandLow),
        .forceError_r(forceErr), .shortMode_r(shortMode),
        .supplyNormal_r(supNorm), .outputPinCommEnable_r(comm),
        .overvoltageEnable_r(ovEn), .diagLatched_r(diagLat),
        .memoryLocked_r(locked));
    ////////////////////////////////////////////////////////////////////
    task wr(input [11:0] a, input [15:0] d);
        begin
            awaddr <= a;
            wdata <= {16'h0000, d};
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            @(posedge clock);
            while (!bvalid) begin
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
                @(posedge clock);
            end
            resp = bresp;
        end
    endtask
    task rchk(input [11:0] a, input [15:0] e);
        begin
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            @(posedge clock);
            while (!rvalid) begin
                if (arready) arvalid <= 1'h0;
                @(posedge clock);
            end
            rd = rdata;
            resp = rresp;
            if (a != 12'h030) `CHK(rd, {16'h0000, e})
        end
    endtask
    task print_verdict;
        begin
            $display("compares %0d errors %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end
    initial begin
        {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 56'h0;
        {err_count, compares, cycles} = 96'h0;
        // input, expected output with clamps 0x1000..0x2000
        tbl[0] = 32'h4000_2000;
        tbl[1] = 32'h0800_1000;
        tbl[2] = 32'hc000_1000;
        tbl[3] = 32'h1800_1800;
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        rchk(`OFS_LIN_GAIN, `RST_LIN_GAIN);
        rchk(`OFS_LIN_OFFSET, `RST_LIN_OFFSET);
        rchk(`OFS_OUT_GAIN, `RST_OUT_GAIN);
        rchk(`OFS_OUT_OFFSET, `RST_OUT_OFFSET);
        rchk(`OFS_CLAMP_HIGH, `RST_CLAMP_HIGH);
        rchk(`OFS_CLAMP_LOW, `RST_CLAMP_LOW);
        for (i = 0; i < 16; i = i + 1)
            rchk(`OFS_SETPOINT_TABLE_BASE + i * 4, 16'h0000);
        rchk(12'h030, 16'h0000);
        `CHK(resp, 2'h2)
        $display("test reset done");
        wr(`OFS_SETUP, 16'hfffe);
        rchk(`OFS_SETUP, 16'h7fbe);
        `CHK({rateSel, supNorm, comm, ovEn}, 5'h06)
        `CHK({bandLow, shortMode, locked}, 4'h0)
        `CHK({periodLog, pol}, 5'h18)
        wr(`OFS_SETUP, 16'h1000);
        @(posedge clock);
        `CHK({supNorm, comm, ovEn}, 3'h1)
        $display("test setup done");
        wr(`OFS_CLAMP_HIGH, 16'h2000);
        wr(`OFS_CLAMP_LOW, 16'h1000);
        for (i = 0; i < 4; i = i + 1) begin
            signal_source_i.set_level(tbl[i][31:16]);
            repeat (4) @(posedge clock);
            `CHK(outValue, tbl[i][15:0])
        end
        wr(`OFS_LIN_OFFSET, 16'hc000);
        repeat (4) @(posedge clock);
        `CHK(outValue, 16'h1000)
        wr(`OFS_OUT_OFFSET, 16'h7fff);
        repeat (4) @(posedge clock);
        `CHK(outValue, 16'h2000)
        rchk(`OFS_RESULT, 16'h2000);
        $display("test path done");
        wr(`OFS_SETUP, 16'h1002);
        signal_source_i.diagError <= 1'h1;
        repeat (4) @(posedge clock);
        `CHK(forceErr, 1'h0)
        wr(`OFS_SETUP, 16'h1000);
        repeat (3) @(posedge clock);
        `CHK(forceErr, 1'h1)
        signal_source_i.diagError <= 1'h0;
        $display("test diagnosis done");
        wr(`OFS_SETUP, 16'h1285);
        `CHK(resp, 2'h0)
        @(posedge clock);
        `CHK({locked, bandLow, shortMode}, 4'hc)
        wr(`OFS_LIN_GAIN, 16'h1234);
        `CHK(resp, 2'h2)
        rchk(`OFS_LIN_GAIN, 16'h4000);
        wr(`OFS_SAMPLE_IN, 16'h0000);
        `CHK(resp, 2'h0)
        signal_source_i.por_pulse;
        repeat (3) @(posedge clock);
        `CHK(shortMode, 2'h2)
        signal_source_i.diagError <= 1'h1;
        @(posedge clock);
        signal_source_i.diagError <= 1'h0;
        repeat (3) @(posedge clock);
        `CHK(diagLat, 1'h1)
        signal_source_i.por_pulse;
        repeat (3) @(posedge clock);
        `CHK(diagLat, 1'h0)
        rchk(`OFS_STATUS, 16'h0006);
        $display("test lock done");
        print_verdict;
    end
endmodule
